// ==== logic/nsg_map.vh ====
// constants for the nonvolatile section write guard
`ifndef NSG_MAP_VH
`define NSG_MAP_VH
`define NSG_PAGE_BYTES 512
`define NSG_PAGE_SHIFT 9
// target memory codes
`define NSG_TGT_FLASH 3'h0
`define NSG_TGT_EEPROM 3'h1
`define NSG_TGT_USERROW 3'h2
`define NSG_TGT_SIGROW 3'h3
`define NSG_TGT_FUSE 3'h4
// operation codes
`define NSG_OP_READ 2'h0
`define NSG_OP_WRITE 2'h1
`define NSG_OP_ERASE 2'h2
`define NSG_OP_CHIP_ERASE 2'h3
// section codes
`define NSG_SEC_LOADER 2'h0
`define NSG_SEC_PROGRAM 2'h1
`define NSG_SEC_PARAM 2'h2
// busy time of an operation in clocks
`define NSG_FLASH_BUSY_CYCLES 16
`define NSG_EEPROM_BUSY_CYCLES 8
`endif

// ==== logic/nsg_guard.v ====
// nonvolatile controller front end with inter-section write protection
// Notes on behaviour
// - flash pages hold 512 bytes, erase unit
// - erase covers whole pages, one or several
// - program writes one byte or one word
// - flash split into loader, program, parameter sections
// - no writes to the executing section
// - program section writable only from loader
// - parameter section writable from loader or program
// - parameter-section code may write only the user row
// - flash writes halt cpu, eeprom writes do not
// - chip erase keeps the user row
// - port writes user row even when locked
// - signature row holds id, serial, calibration
// - all nonvolatile access passes this block
// - section ends from fuses in page units
// - zero loader fuse makes all flash loader
// - reads stall while write or erase busy
`timescale 1ns/1ps
`default_nettype none
`include "nsg_map.vh"

module nsg_guard #(
  parameter ADDR_W = 15,          // flash byte address width
  parameter FUSE_W = 8,           // size fuse width
  parameter PAGE_CNT_W = 6,       // erase page count width
  parameter DEVICE_ID = 24'h5a5a01, // arbitrary neutral identity value
  parameter SERIAL_NO = 32'h00000001, // arbitrary serial value
  parameter CAL_BYTES = 16'h8080  // arbitrary calibration bytes
) (
  input wire i_clock, // system clock 40 MHz
  input wire i_reset_n, // asynchronous reset, active low
  input wire i_req, // request strobe, one cycle
  input wire i_from_port, // request from external programming port
  input wire [1:0] i_op, // operation code
  input wire [2:0] i_target, // target memory
  input wire [ADDR_W-1:0] i_addr, // byte address within target
  input wire [15:0] i_wdata, // write data
  input wire i_word, // write one 16-bit word, else one byte
  input wire [PAGE_CNT_W-1:0] i_page_cnt, // erase page count minus one
  input wire [ADDR_W-1:0] i_exec_pc, // byte address of the issuing fetch
  input wire [FUSE_W-1:0] i_loader_size_fuse, // loader size in pages
  input wire [FUSE_W-1:0] i_program_region_size_fuse, // program end in pages
  input wire i_locked, // device lock state
  input wire i_nvm_done, // array reports operation finished
  input wire [15:0] i_nvm_rdata, // array read data
  output reg o_ack, // request completed, one cycle
  output reg o_refused, // request refused, one cycle
  output reg [15:0] o_rdata, // read data, valid with o_ack
  output reg o_wait, // bus stall
  output reg o_cpu_halt, // processor halt
  output reg o_nvm_start, // start array operation, one cycle
  output reg [1:0] o_nvm_op, // array operation
  output reg [2:0] o_nvm_target, // array target
  output reg [ADDR_W-1:0] o_nvm_addr, // page-aligned for flash erase
  output reg [15:0] o_nvm_wdata, // array write data
  output reg o_nvm_word, // word write
  output reg [PAGE_CNT_W-1:0] o_nvm_page_cnt, // pages to erase minus one
  output reg o_nvm_keep_userrow // chip erase spares user row
);

  // ------------------------------------------------------------
  // section map
  // ------------------------------------------------------------
  localparam PAGE_BITS = ADDR_W - `NSG_PAGE_SHIFT;

  // classify a byte address into a section from the two fuses
  function [1:0] section_of;
    input [ADDR_W-1:0] a;
    input [FUSE_W-1:0] lsz;
    input [FUSE_W-1:0] psz;
    reg [FUSE_W-1:0] pg;
    begin
      pg = {{(FUSE_W-PAGE_BITS){1'b0}}, a[ADDR_W-1:`NSG_PAGE_SHIFT]};
      if (lsz == {FUSE_W{1'b0}}) begin
        section_of = `NSG_SEC_LOADER;
      end else if (pg < lsz) begin
        section_of = `NSG_SEC_LOADER;
      end else if (psz == {FUSE_W{1'b0}}) begin
        section_of = `NSG_SEC_PROGRAM;
      end else if (psz <= lsz) begin
        section_of = `NSG_SEC_PARAM;
      end else if (pg < psz) begin
        section_of = `NSG_SEC_PROGRAM;
      end else begin
        section_of = `NSG_SEC_PARAM;
      end
    end
  endfunction

  // ------------------------------------------------------------
  // request decode and protection
  // ------------------------------------------------------------
  localparam ST_IDLE = 3'h1;
  localparam ST_BUSY = 3'h2;
  localparam ST_READ = 3'h4;

  reg [2:0] state;
  reg [2:0] next_state;
  reg read_pend;

  wire [1:0] exec_sec = section_of(i_exec_pc, i_loader_size_fuse, i_program_region_size_fuse);
  wire [1:0] tgt_sec = section_of(i_addr, i_loader_size_fuse, i_program_region_size_fuse);
  wire is_read = (i_op == `NSG_OP_READ);
  wire is_flash = (i_target == `NSG_TGT_FLASH);

  reg allowed;
  reg halt_needed;
  always @* begin
    allowed = 1'b0;
    halt_needed = 1'b0;
    if (is_read) begin
      allowed = 1'b1;
    end else if (i_from_port) begin
      // port may write everything but the signature row, user row even if locked
      allowed = (i_target != `NSG_TGT_SIGROW) &&
        (!i_locked || i_target == `NSG_TGT_USERROW);
    end else if (i_op == `NSG_OP_CHIP_ERASE) begin
      allowed = 1'b0;
    end else begin
      case (i_target)
        `NSG_TGT_FLASH: begin
          if (exec_sec == `NSG_SEC_PARAM) begin
            allowed = 1'b0;
          end else if (tgt_sec == exec_sec) begin
            allowed = 1'b0;
          end else if (tgt_sec == `NSG_SEC_PROGRAM) begin
            allowed = (exec_sec == `NSG_SEC_LOADER);
          end else begin
            allowed = (tgt_sec == `NSG_SEC_PARAM);
          end
          halt_needed = allowed;
        end
        `NSG_TGT_EEPROM: allowed = (exec_sec != `NSG_SEC_PARAM);
        `NSG_TGT_USERROW: allowed = 1'b1;
        default: allowed = 1'b0; // signature row and fuses are not cpu-writable
      endcase
    end
  end

  // ------------------------------------------------------------
  // sequencing
  // ------------------------------------------------------------
  always @* begin
    next_state = state;
    case (state)
      ST_IDLE: begin
        if (i_req && allowed && !is_read) begin
          next_state = ST_BUSY;
        end else if (i_req && is_read) begin
          next_state = ST_READ;
        end
      end
      ST_BUSY: begin
        if (i_nvm_done) begin
          next_state = read_pend ? ST_READ : ST_IDLE;
        end
      end
      ST_READ: next_state = ST_IDLE;
      default: next_state = ST_IDLE;
    endcase
  end

  always @(posedge i_clock or negedge i_reset_n) begin
    if (!i_reset_n) begin
      state <= ST_IDLE;
      read_pend <= 1'b0;
      o_ack <= 1'b0;
      o_refused <= 1'b0;
      o_rdata <= 16'h0000;
      o_wait <= 1'b0;
      o_cpu_halt <= 1'b0;
      o_nvm_start <= 1'b0;
      o_nvm_op <= `NSG_OP_READ;
      o_nvm_target <= `NSG_TGT_FLASH;
      o_nvm_addr <= {ADDR_W{1'b0}};
      o_nvm_wdata <= 16'h0000;
      o_nvm_word <= 1'b0;
      o_nvm_page_cnt <= {PAGE_CNT_W{1'b0}};
      o_nvm_keep_userrow <= 1'b0;
    end else begin
      state <= next_state;
      o_ack <= 1'b0;
      o_refused <= 1'b0;
      o_nvm_start <= 1'b0;
      case (state)
        ST_IDLE: begin
          if (i_req && !is_read && !allowed) begin
            o_refused <= 1'b1;
          end else if (i_req && !is_read) begin
            // all array writes and erases issue here, reads start no array operation
            o_nvm_start <= 1'b1;
            o_nvm_op <= i_op;
            o_nvm_target <= i_target;
            o_nvm_wdata <= i_wdata;
            o_nvm_word <= i_word;
            o_nvm_page_cnt <= i_page_cnt;
            o_nvm_keep_userrow <= (i_op == `NSG_OP_CHIP_ERASE);
            if (i_op == `NSG_OP_ERASE && is_flash) begin
              // flash erase is rounded down to the page start
              o_nvm_addr <= {i_addr[ADDR_W-1:`NSG_PAGE_SHIFT],
                {`NSG_PAGE_SHIFT{1'b0}}};
            end else if (i_word) begin
              o_nvm_addr <= {i_addr[ADDR_W-1:1], 1'b0};
            end else begin
              o_nvm_addr <= i_addr;
            end
            o_cpu_halt <= halt_needed && !i_from_port;
          end else if (i_req && is_read) begin
            o_ack <= 1'b1;
            // signature row answers from fixed values here; a read held behind a write gets i_nvm_rdata
            if (i_target == `NSG_TGT_SIGROW) begin
              o_rdata <= sig_byte(i_addr[3:0]);
            end else begin
              o_rdata <= i_nvm_rdata;
            end
          end
        end
        ST_BUSY: begin
          o_wait <= (i_req && is_read) || (read_pend && !i_nvm_done);
          if (i_req && is_read) begin
            read_pend <= 1'b1;
          end
          if (i_nvm_done) begin
            o_cpu_halt <= 1'b0;
            o_ack <= !read_pend;
          end
        end
        ST_READ: begin
          o_wait <= 1'b0;
          if (read_pend) begin
            read_pend <= 1'b0;
            o_ack <= 1'b1;
            o_rdata <= i_nvm_rdata;
          end
        end
        default: o_wait <= 1'b0;
      endcase
    end
  end

  // signature row contents: id, serial, calibration
  function [15:0] sig_byte;
    input [3:0] idx;
    begin
      case (idx)
        4'h0: sig_byte = {8'h00, DEVICE_ID[23:16]};
        4'h1: sig_byte = {8'h00, DEVICE_ID[15:8]};
        4'h2: sig_byte = {8'h00, DEVICE_ID[7:0]};
        4'h4: sig_byte = {8'h00, SERIAL_NO[31:24]};
        4'h5: sig_byte = {8'h00, SERIAL_NO[23:16]};
        4'h6: sig_byte = {8'h00, SERIAL_NO[15:8]};
        4'h7: sig_byte = {8'h00, SERIAL_NO[7:0]};
        4'h8: sig_byte = {8'h00, CAL_BYTES[15:8]};
        4'h9: sig_byte = {8'h00, CAL_BYTES[7:0]};
        default: sig_byte = 16'h0000;
      endcase
    end
  endfunction

endmodule // nsg_guard
`default_nettype wire

// ==== verification/nsg_guard_assertions.sv ====
// concurrent checks on the section write guard ports
`timescale 1ns/1ps
`default_nettype none
module nsg_guard_assertions #(parameter ADDR_W = 15, parameter FUSE_W = 8) (
  input wire i_clock, i_reset_n, i_req, i_from_port, i_nvm_done,
  input wire [1:0] i_op,
  input wire [2:0] i_target,
  input wire [ADDR_W-1:0] i_addr, i_exec_pc,
  input wire [FUSE_W-1:0] i_loader_size_fuse, i_program_region_size_fuse,
  input wire o_ack, o_refused, o_wait, o_cpu_halt, o_nvm_start, o_nvm_word,
  input wire o_nvm_keep_userrow,
  input wire [1:0] o_nvm_op,
  input wire [2:0] o_nvm_target,
  input wire [ADDR_W-1:0] o_nvm_addr
);
  reg bsy;
  wire [FUSE_W-1:0] lz = i_loader_size_fuse;
  wire [FUSE_W-1:0] pz = i_program_region_size_fuse;
  function automatic [1:0] sec(input [ADDR_W-1:0] a);
    sec = (!lz || a[ADDR_W-1:9] < lz) ? 2'h0 :
      (!pz || (pz > lz && a[ADDR_W-1:9] < pz)) ? 2'h1 : 2'h2;
  endfunction
  wire [1:0] sp = sec(i_exec_pc);
  wire [1:0] sa = sec(i_addr);
  wire idle = !bsy && !o_nvm_start;
  wire cw = i_req && idle && !i_from_port && i_op == 2'h1;
  wire fok = (sp == 2'h0 && sa != 2'h0) || (sp == 2'h1 && sa == 2'h2);
  // busy spans start to ack, so a read in that span must be stalled
  always @(posedge i_clock or negedge i_reset_n) begin
    if (!i_reset_n) bsy <= 1'h0;
    else if (o_nvm_start) bsy <= 1'h1;
    else if (o_ack) bsy <= 1'h0;
  end
  default clocking @(posedge i_clock); endclocking
  default disable iff (!i_reset_n);
  refused_clean_a: assert property (o_refused |-> !o_nvm_start && !o_cpu_halt)
    else $error("refused request started");
  flash_guard_a: assert property (cw && i_target == 3'h0 && !fok |=> o_refused)
    else $error("flash write not refused");
  flash_allow_a: assert property (cw && i_target == 3'h0 && fok |=> o_nvm_start && o_cpu_halt)
    else $error("flash write not halted");
  eeprom_guard_a: assert property (cw && i_target == 3'h1 && sp == 2'h2 |=> o_refused)
    else $error("eeprom write not refused");
  halt_release_a: assert property (o_cpu_halt && i_nvm_done |=> o_ack && !o_cpu_halt)
    else $error("halt not released");
  erase_align_a: assert property (o_nvm_start && o_nvm_op == 2'h2 && o_nvm_target == 3'h0
    |-> o_nvm_addr[8:0] == 9'h0) else $error("erase not page aligned");
  word_align_a: assert property (o_nvm_start && o_nvm_op == 2'h1 && o_nvm_word |-> !o_nvm_addr[0])
    else $error("word write odd");
  chip_keep_a: assert property (o_nvm_start && o_nvm_op == 2'h3 |-> o_nvm_keep_userrow)
    else $error("chip erase hits user row");
  read_stall_a: assert property (i_req && i_op == 2'h0 && !idle |=> o_wait)
    else $error("busy read not stalled");
endmodule // nsg_guard_assertions
`default_nettype wire

// ==== verification/nsg_array_model.sv ====
// array timing model answering the guard's start strobes
`timescale 1ns/1ps
`default_nettype none
module nsg_array_model (
  input wire logic i_clock, // clock
  input wire logic i_reset_n, // reset, active low
  input wire logic i_start, // operation start
  input wire logic [7:0] i_lat, // busy cycles before done
  output logic o_done, // done pulse
  output logic [15:0] o_rdata // read data
);
  logic [7:0] cnt;
  logic run;
  // fixed pattern: the bench knows the answer without a memory copy
  assign o_rdata = 16'h3c5a;
  always @(posedge i_clock or negedge i_reset_n) begin
    if (!i_reset_n) begin
      {run, cnt, o_done} <= 10'h0;
    end else begin
      o_done <= run && cnt == 8'h0;
      if (i_start) {run, cnt} <= {1'h1, i_lat};
      else if (cnt != 8'h0) cnt <= cnt - 8'h1;
      else run <= 1'h0;
    end
  end
endmodule // nsg_array_model
`default_nettype wire

// ==== verification/nsg_guard_test.sv ====
// self-checking bench for the section write guard
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin tests_run++; if ((a) !== (b)) begin bad_count++; \
  $display("ERROR %0t result mismatch", $time); end end
module nsg_guard_test;
  logic i_clock = 1'h0, i_reset_n = 1'h0, i_req = 1'h0, i_from_port = 1'h0;
  logic i_word = 1'h0, i_locked = 1'h0;
  logic [1:0] i_op = 2'h0;
  logic [2:0] i_target = 3'h0;
  logic [14:0] i_addr = 15'h0, i_exec_pc = 15'h0;
  logic [15:0] i_wdata = 16'h0;
  logic [5:0] i_page_cnt = 6'h0;
  logic [7:0] i_loader_size_fuse = 8'h4, i_program_region_size_fuse = 8'h8, lat = 8'h3;
  wire o_ack, o_refused, o_wait, o_cpu_halt, o_nvm_start, o_nvm_word, o_nvm_keep_userrow;
  wire i_nvm_done;
  wire [1:0] o_nvm_op;
  wire [2:0] o_nvm_target;
  wire [14:0] o_nvm_addr;
  wire [15:0] o_rdata, o_nvm_wdata, i_nvm_rdata;
  wire [5:0] o_nvm_page_cnt;
  int bad_count = 0, tests_run = 0;
  logic [17:0] q[$];
  logic [17:0] n;
  logic [22:0] last_cmd = 23'h0;
  logic [2:0] last_t = 3'h0;
  bit ok;
  always #12.5 i_clock = ~i_clock;
  nsg_guard dut (.*);
  nsg_array_model mdl (.i_clock(i_clock), .i_reset_n(i_reset_n), .i_start(o_nvm_start),
    .i_lat(lat), .o_done(i_nvm_done), .o_rdata(i_nvm_rdata));
  // each result pops the oldest note: {refused, is read, data}
  always @(posedge i_clock) begin
    if (o_ack === 1'h1 || o_refused === 1'h1) begin
      n = q.pop_front();
      `CHK(o_refused, n[17])
      if (n[16]) `CHK(o_rdata, n[15:0])
    end
    if (o_nvm_start === 1'h1) begin
      `CHK({o_nvm_wdata, o_nvm_word, o_nvm_page_cnt}, last_cmd)
      `CHK(o_nvm_target, last_t)
    end
  end
  function automatic logic [14:0] at(input int s);
    return 15'(s * 15'h800 + $urandom % 15'h800);
  endfunction
  task automatic go(input logic p, input logic [1:0] op, input logic [2:0] t,
    input logic [14:0] a, input logic [14:0] pc, input logic [17:0] e, input bit nw = 0);
    int k;
    int unsigned r;
    r = $urandom;
    @(posedge i_clock);
    {i_req, i_from_port, i_op, i_target, i_addr, i_exec_pc} <= {1'h1, p, op, t, a, pc};
    {i_wdata, i_word, i_page_cnt} <= 23'(r);
    last_cmd <= 23'(r);
    last_t <= t;
    // a write overlapped by a read gives its ack to that read, so it gets no note
    if (!nw) q.push_back(e);
    @(posedge i_clock);
    i_req <= 1'h0;
    for (k = 0; k < 100 && q.size() > 0 && !nw; k++) @(posedge i_clock);
    if (!nw && q.size() > 0) begin
      bad_count++;
      $display("ERROR %0t no result", $time);
      q.delete();
    end
  endtask
  task automatic summarize;
    $display("checks %0d errors %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  initial begin
    #500000;
    bad_count++;
    summarize();
  end
  initial begin
    void'($urandom(14104));
    repeat (10) @(posedge i_clock);
    i_reset_n <= 1'h1;
    for (int s = 0; s < 3; s++) begin
      for (int t = 0; t < 4; t++) begin
        ok = t == 3 ? s != 2 : (s == 0 && t != 0) || (s == 1 && t == 2);
        go(0, 1, 3'(t == 3), at(t % 3), at(s), ok ? 18'h0 : 18'h20000);
      end
    end
    go(0, 2, 0, at(1), at(0), 18'h0);
    go(0, 3, 0, 15'h0, at(0), 18'h20000);
    go(1, 3, 0, 15'h0, 15'h0, 18'h0);
    go(1, 1, 3, 15'h1, 15'h0, 18'h20000);
    go(0, 0, 3, 15'h2, at(0), 18'h10001);
    i_locked <= 1'h1;
    go(1, 1, 2, 15'h5, 15'h0, 18'h0);
    go(1, 1, 0, 15'h5, 15'h0, 18'h20000);
    i_locked <= 1'h0;
    go(1, 1, 0, at(2), 15'h0, 18'h0, 1);
    go(1, 0, 0, at(0), 15'h0, 18'h13c5a);
    lat <= 8'h0;
    go(0, 1, 0, at(2), at(0), 18'h0);
    i_loader_size_fuse <= 8'h0;
    go(0, 1, 0, at(2), at(1), 18'h20000);
    {i_loader_size_fuse, i_program_region_size_fuse} <= 16'h0402;
    go(0, 1, 0, at(1), at(0), 18'h0);
    go(0, 1, 1, 15'h3, at(1), 18'h20000);
    summarize();
  end
endmodule // nsg_guard_test
bind nsg_guard nsg_guard_assertions #(.ADDR_W(ADDR_W), .FUSE_W(FUSE_W)) chk (.*);
`default_nettype wire
